// ---- design/rsc_reset_ctrl.sv ----
// Reset source controller: sequencer, flags and init strobes
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - A sleep or idle watchdog time-out clears program counter, its low byte and stack pointer, and sets TO.
// - A sleep or idle watchdog time-out also sets PDF and clears the watchdog counter, and leaves every other register untouched.
// - Time-out and power-down flags are kept and follow watchdog and low-power activity.
// - Power-on clears both time-out and power-down flags.
// - A running-mode watchdog time-out sets time-out and keeps power-down as it was.
// - A sleep or idle watchdog time-out sets both time-out and power-down.
// - Power-on disables every interrupt source by clearing the interrupt controls.
// - Every reset clears the watchdog counter and time base, and the watchdog restarts at once.
// - Power-on switches the timer module off by clearing its control, compare and period registers.
// - Power-on makes all port pins inputs and disables pull-ups and wake-up.
// - Power-on starts execution at address zero with the stack pointer at its top.
// - A running-mode watchdog time-out reloads control registers but keeps accumulator and table pointer.
// - A watchdog time-out in normal operation reloads the control registers without power-on init and sets time-out.
// - A key field other than the two valid codes resets after a fixed delay and sets the write reset flag.
module rsc_reset_ctrl (
	// Clock and power-on reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Reset sources and mode
	input wire logic por_req,
	input wire logic wdt_timeout,
	input wire logic low_power,
	input wire logic [4:0] watchdog_key_field,
	input wire logic halt_enter,
	input wire logic clr_wdt,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	// Reset flags
	output logic timeout_flag,
	output logic power_down_flag,
	output logic control_write_reset_flag,
	// Init strobes and core hold
	output logic pc_sp_clr,
	output logic por_init,
	output logic [3:0] ctrl_init,
	output logic wdt_tb_clr,
	output logic core_hold,
	output logic [2:0] reset_cause
);
	rsc_link_if lk ();

	rsc_pkg::rsc_state_t state_q;
	rsc_pkg::rsc_state_t state_d;
	rsc_pkg::rsc_cause_t cin;
	rsc_pkg::rsc_cause_t cause_q;
	logic [3:0] hold_q;
	logic [3:0] hold_d;
	logic to_q;
	logic pdf_q;
	logic wrf_q;
	logic pc_sp_q;
	logic por_init_q;
	logic [3:0] init_q;
	logic wdt_tb_q;
	logic core_hold_q;
	wire logic take;
	wire logic is_por;
	wire logic is_run;
	wire logic is_lp;
	wire logic is_key;
	wire logic to_d;
	wire logic pdf_d;
	wire logic wrf_d;

	rsc_cause_det u_det (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.por_req(por_req),
		.wdt_timeout(wdt_timeout),
		.low_power(low_power),
		.watchdog_key_field(watchdog_key_field),
		.lk(lk.det)
	);

	rsc_regs u_regs (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.irq(irq),
		.lk(lk.regs)
	);

	// A cause is taken while running; power-on is taken in any state
	assign cin = lk.cause;
	assign take = (cin != rsc_pkg::RSC_NONE) && ((state_q == rsc_pkg::RSC_ST_RUN) || (cin == rsc_pkg::RSC_POR));
	assign is_por = take && (cin == rsc_pkg::RSC_POR);
	assign is_run = take && (cin == rsc_pkg::RSC_WDT_RUN);
	assign is_lp = take && (cin == rsc_pkg::RSC_WDT_LP);
	assign is_key = take && (cin == rsc_pkg::RSC_KEY);

	// One event pulse per cause toward the status register
	for (genvar i = 0; i < 4; i++) begin : g_ev
		assign lk.ev[i] = take && (cin == rsc_pkg::rsc_cause_t'(3'(i + 1)));
	end
	assign lk.flags = {wrf_q, pdf_q, to_q};

	// Reset events win over software activity in the same cycle, except that halt or clear-watchdog still clears TO on a key reset
	assign to_d = (is_run || is_lp) ? 1'b1 :
		(is_por || halt_enter || clr_wdt) ? 1'b0 : to_q;
	assign pdf_d = is_lp ? 1'b1 : is_por ? 1'b0 :
		(is_run || is_key) ? pdf_q :
		halt_enter ? 1'b1 : clr_wdt ? 1'b0 : pdf_q;
	assign wrf_d = is_key ? 1'b1 : (is_por || lk.wrf_clr) ? 1'b0 : wrf_q;

	always_comb begin
		state_d = state_q;
		hold_d = hold_q;
		case (state_q)
			rsc_pkg::RSC_ST_RUN: state_d = rsc_pkg::RSC_ST_RUN;
			rsc_pkg::RSC_ST_APPLY: begin
				state_d = rsc_pkg::RSC_ST_HOLD;
				hold_d = lk.hold_ext;
			end
			rsc_pkg::RSC_ST_HOLD: begin
				if (hold_q == 4'h0) begin
					state_d = rsc_pkg::RSC_ST_RUN;
				end else begin
					hold_d = hold_q - 4'h1;
				end
			end
			default: state_d = rsc_pkg::RSC_ST_RUN;
		endcase
		if (take) begin
			state_d = rsc_pkg::RSC_ST_APPLY;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= rsc_pkg::RSC_ST_RUN;
			hold_q <= 4'h0;
			cause_q <= rsc_pkg::RSC_NONE;
			to_q <= 1'b0;
			pdf_q <= 1'b0;
			wrf_q <= 1'b0;
		end else begin
			state_q <= state_d;
			hold_q <= hold_d;
			cause_q <= take ? cin : cause_q;
			to_q <= to_d;
			pdf_q <= pdf_d;
			wrf_q <= wrf_d;
		end
	end

	// Strobes; sleep wake-up skips the reload so register contents survive
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_sp_q <= 1'b0;
			por_init_q <= 1'b0;
			init_q <= 4'h0;
			wdt_tb_q <= 1'b0;
			core_hold_q <= 1'b0;
		end else begin
			pc_sp_q <= take;
			por_init_q <= is_por;
			init_q <= {4{take && !is_lp}};
			wdt_tb_q <= take;
			core_hold_q <= state_d != rsc_pkg::RSC_ST_RUN;
		end
	end

	assign timeout_flag = to_q;
	assign power_down_flag = pdf_q;
	assign control_write_reset_flag = wrf_q;
	assign pc_sp_clr = pc_sp_q;
	assign por_init = por_init_q;
	assign ctrl_init = init_q;
	assign wdt_tb_clr = wdt_tb_q;
	assign core_hold = core_hold_q;
	assign reset_cause = cause_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_lp_core;
		is_lp |=> pc_sp_clr && timeout_flag && wdt_tb_clr;
	endproperty
	a_lp_core: assert property (p_lp_core)
		else $error("sleep time-out did not clear pc and stack");
	property p_lp_keep;
		is_lp |=> ctrl_init == 4'h0 && !por_init;
	endproperty
	a_lp_keep: assert property (p_lp_keep)
		else $error("sleep time-out disturbed preserved registers");
	property p_halt_flags;
		halt_enter && !take |=> power_down_flag && !timeout_flag;
	endproperty
	a_halt_flags: assert property (p_halt_flags)
		else $error("halt entry did not update flags");
	property p_por_flags;
		is_por |=> !timeout_flag && !power_down_flag && !control_write_reset_flag;
	endproperty
	a_por_flags: assert property (p_por_flags)
		else $error("power-on did not clear flags");
	property p_run_flags;
		is_run |=> timeout_flag && power_down_flag == $past(pdf_q);
	endproperty
	a_run_flags: assert property (p_run_flags)
		else $error("running time-out flags wrong");
	property p_lp_flags;
		is_lp |=> timeout_flag && power_down_flag;
	endproperty
	a_lp_flags: assert property (p_lp_flags)
		else $error("sleep time-out flags wrong");
	property p_por_init;
		is_por |=> por_init && pc_sp_clr && ctrl_init == 4'hf;
	endproperty
	a_por_init: assert property (p_por_init)
		else $error("power-on init strobes missing");
	property p_wdt_clr;
		take |=> wdt_tb_clr && core_hold;
	endproperty
	a_wdt_clr: assert property (p_wdt_clr)
		else $error("watchdog clear strobe missing");
	property p_run_reload;
		is_run |=> ctrl_init == 4'hf && !por_init;
	endproperty
	a_run_reload: assert property (p_run_reload)
		else $error("running time-out reload wrong");
	property p_run_hold;
		is_run |=> core_hold [*2];
	endproperty
	a_run_hold: assert property (p_run_hold)
		else $error("core not held after running time-out");
	property p_key_flag;
		is_key |=> control_write_reset_flag && ctrl_init == 4'hf;
	endproperty
	a_key_flag: assert property (p_key_flag)
		else $error("key reset did not set write reset flag");
	property p_clr_flags;
		clr_wdt && !halt_enter && !take |=> !timeout_flag && !power_down_flag;
	endproperty
	a_clr_flags: assert property (p_clr_flags)
		else $error("clear-watchdog did not clear flags");
	property p_key_keep;
		is_key && !halt_enter && !clr_wdt |=> timeout_flag == $past(to_q) && power_down_flag == $past(pdf_q);
	endproperty
	a_key_keep: assert property (p_key_keep)
		else $error("key reset changed time-out or power-down flag");
	property p_wrf_clr;
		lk.wrf_clr && !is_key |=> !control_write_reset_flag;
	endproperty
	a_wrf_clr: assert property (p_wrf_clr)
		else $error("write reset flag not cleared by software");
	property p_lp_wrf;
		is_lp && !lk.wrf_clr |=> control_write_reset_flag == $past(wrf_q);
	endproperty
	a_lp_wrf: assert property (p_lp_wrf)
		else $error("sleep time-out disturbed write reset flag");
	property p_run_wrf;
		is_run && !lk.wrf_clr |=> control_write_reset_flag == $past(wrf_q);
	endproperty
	a_run_wrf: assert property (p_run_wrf)
		else $error("running time-out disturbed write reset flag");
	property p_cause_out;
		take |=> reset_cause == $past(cin);
	endproperty
	a_cause_out: assert property (p_cause_out)
		else $error("reset cause output wrong");
	property p_hold_load;
		state_q == rsc_pkg::RSC_ST_APPLY && !take |=> hold_q == $past(lk.hold_ext);
	endproperty
	a_hold_load: assert property (p_hold_load)
		else $error("extra hold count not loaded");
	property p_hold_end;
		state_q == rsc_pkg::RSC_ST_HOLD && hold_q == 4'h0 && !take |=> !core_hold;
	endproperty
	a_hold_end: assert property (p_hold_end)
		else $error("core not released at end of hold");
	property p_strobe_once;
		!take |=> !pc_sp_clr && !wdt_tb_clr && !por_init && ctrl_init == 4'h0;
	endproperty
	a_strobe_once: assert property (p_strobe_once)
		else $error("init strobe without a taken cause");
	property p_por_strobes;
		por_req |=> ##1 por_init && pc_sp_clr;
	endproperty
	a_por_strobes: assert property (p_por_strobes)
		else $error("power-on request did not reach the init strobes");

	c_por: cover property (is_por);
	c_run: cover property (is_run);
	c_lp: cover property (is_lp);
	c_key: cover property (is_key ##1 lk.wrf_clr);
	c_hold: cover property (state_q == rsc_pkg::RSC_ST_HOLD && hold_q != 4'h0);
endmodule : rsc_reset_ctrl
`default_nettype wire

// ---- design/rsc_pkg.sv ----
// Shared types and constants of the reset source controller
package rsc_pkg;
	typedef enum logic [2:0] {
		RSC_NONE = 3'h0,
		RSC_POR = 3'h1,
		RSC_WDT_RUN = 3'h2,
		RSC_WDT_LP = 3'h3,
		RSC_KEY = 3'h4
	} rsc_cause_t;
	typedef enum logic [1:0] {
		RSC_ST_RUN = 2'h0,
		RSC_ST_APPLY = 2'h1,
		RSC_ST_HOLD = 2'h2
	} rsc_state_t;
	// Watchdog key field codes
	localparam logic [4:0] KEY_ENABLE = 5'h0a;
	localparam logic [4:0] KEY_DISABLE = 5'h15;
	// Delay from a bad key to the reset
	localparam int CLK_HZ = 10000000;
	localparam int T_SRESET_NS = 2000;
	localparam int T_SRESET_CYC = (T_SRESET_NS * (CLK_HZ / 1000000) + 999) / 1000;
	// Register byte offsets
	localparam logic [3:0] OFS_FLAGS = 4'h0;
	localparam logic [3:0] OFS_EVT = 4'h4;
	localparam logic [3:0] OFS_MASK = 4'h8;
	localparam logic [3:0] OFS_CTRL = 4'hc;
	// Flag bit positions
	localparam int FLG_TO = 0;
	localparam int FLG_PDF = 1;
	localparam int FLG_WRF = 2;
	// Init strobe bit positions
	localparam int INIT_INTC = 0;
	localparam int INIT_TMR = 1;
	localparam int INIT_PORT = 2;
	localparam int INIT_WATCHDOG_CONTROL = 3;
	// Values after reset
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic [3:0] HOLD_RST = 4'h0;
	localparam logic [31:0] RDATA_RST = 32'h0;
endpackage : rsc_pkg

// ---- design/rsc_link_if.sv ----
// Signals between the sequencer, the cause detector and the register slave
`timescale 1ns/10ps
`default_nettype none
interface rsc_link_if;
	rsc_pkg::rsc_cause_t cause;
	logic [3:0] ev;
	logic [2:0] flags;
	logic wrf_clr;
	logic [3:0] hold_ext;
	modport det (output cause);
	modport regs (input ev, input flags, output wrf_clr, output hold_ext);
	modport ctl (input cause, input wrf_clr, input hold_ext, output ev, output flags);
endinterface : rsc_link_if
`default_nettype wire

// ---- design/rsc_cause_det.sv ----
// Reset cause detection and priority
`timescale 1ns/10ps
`default_nettype none
module rsc_cause_det (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Reset sources
	input wire logic por_req,
	input wire logic wdt_timeout,
	input wire logic low_power,
	input wire logic [4:0] watchdog_key_field,
	// Cause to the sequencer
	rsc_link_if.det lk
);
	localparam int KD = rsc_pkg::T_SRESET_CYC;

	logic por_pend_q;
	logic armed_q;
	logic [7:0] cnt_q;
	rsc_pkg::rsc_cause_t cause_q;
	rsc_pkg::rsc_cause_t cause_d;
	wire logic key_bad;
	wire logic key_fire;

	assign key_bad = (watchdog_key_field != rsc_pkg::KEY_ENABLE) &&
		(watchdog_key_field != rsc_pkg::KEY_DISABLE);
	assign key_fire = key_bad && armed_q && (cnt_q == 8'(KD - 1));
	// Power-on outranks every other source
	assign cause_d = (por_pend_q || por_req) ? rsc_pkg::RSC_POR :
		key_fire ? rsc_pkg::RSC_KEY :
		wdt_timeout ? (low_power ? rsc_pkg::RSC_WDT_LP : rsc_pkg::RSC_WDT_RUN) :
		rsc_pkg::RSC_NONE;
	assign lk.cause = cause_q;

	// One shot per bad key; re-armed only once the field reads valid again
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			por_pend_q <= 1'b1;
			armed_q <= 1'b1;
			cnt_q <= 8'h0;
			cause_q <= rsc_pkg::RSC_NONE;
		end else begin
			por_pend_q <= 1'b0;
			armed_q <= !key_bad || (armed_q && !key_fire);
			cnt_q <= (key_bad && armed_q && !key_fire) ? cnt_q + 8'h1 : 8'h0;
			cause_q <= cause_d;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_por_wins;
		por_req |=> lk.cause == rsc_pkg::RSC_POR;
	endproperty
	a_por_wins: assert property (p_por_wins)
		else $error("power-on request not taken as power-on cause");
	property p_key_delay;
		lk.cause == rsc_pkg::RSC_KEY |-> $past(key_bad, 1) && $past(key_bad, KD);
	endproperty
	a_key_delay: assert property (p_key_delay)
		else $error("key reset without full delay of bad key");
	property p_lp_cause;
		wdt_timeout && low_power && !por_req && !por_pend_q && !key_fire |=> lk.cause == rsc_pkg::RSC_WDT_LP;
	endproperty
	a_lp_cause: assert property (p_lp_cause)
		else $error("sleep time-out not classed as low-power cause");
endmodule : rsc_cause_det
`default_nettype wire

// ---- design/rsc_regs.sv ----
// Avalon-MM register slave with event status, mask and interrupt
`timescale 1ns/10ps
`default_nettype none
module rsc_regs (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	// Sequencer side
	rsc_link_if.regs lk
);
	logic wait_q;
	logic irq_q;
	logic [31:0] rdata_q;
	logic [3:0] evt_q;
	logic [3:0] mask_q;
	logic [3:0] hold_q;
	wire logic req;
	wire logic wr;
	wire logic sel_flags;
	wire logic sel_evt;
	wire logic sel_mask;
	wire logic sel_ctrl;
	wire logic [31:0] rd_mux;
	wire logic [3:0] evt_d;
	wire logic [3:0] mask_d;

	assign req = avs_read || avs_write;
	assign wr = avs_write && !wait_q;
	assign sel_flags = avs_address == rsc_pkg::OFS_FLAGS;
	assign sel_evt = avs_address == rsc_pkg::OFS_EVT;
	assign sel_mask = avs_address == rsc_pkg::OFS_MASK;
	assign sel_ctrl = avs_address == rsc_pkg::OFS_CTRL;
	// Unmapped offsets read zero and ignore writes
	assign rd_mux = sel_flags ? {29'h0, lk.flags} :
		sel_evt ? {28'h0, evt_q} :
		sel_mask ? {28'h0, mask_q} :
		sel_ctrl ? {28'h0, hold_q} : 32'h0;
	// New event beats a write-one clear in the same cycle
	assign evt_d = (evt_q & ~((wr && sel_evt) ? avs_writedata[3:0] : 4'h0)) | lk.ev;
	assign mask_d = (wr && sel_mask) ? avs_writedata[3:0] : mask_q;
	assign lk.wrf_clr = wr && sel_flags && avs_writedata[rsc_pkg::FLG_WRF];
	assign lk.hold_ext = hold_q;
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign irq = irq_q;

	// Fixed one wait state keeps the read mux out of the bus timing path
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= 1'b1;
			rdata_q <= rsc_pkg::RDATA_RST;
			evt_q <= 4'h0;
			mask_q <= rsc_pkg::MASK_RST;
			hold_q <= rsc_pkg::HOLD_RST;
			irq_q <= 1'b0;
		end else begin
			wait_q <= !(req && wait_q);
			rdata_q <= (avs_read && wait_q) ? rd_mux : rdata_q;
			evt_q <= evt_d;
			mask_q <= mask_d;
			hold_q <= (wr && sel_ctrl) ? avs_writedata[3:0] : hold_q;
			irq_q <= |(evt_d & mask_d);
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_wait_ack;
		req && wait_q |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_wait_ack: assert property (p_wait_ack)
		else $error("waitrequest did not drop for exactly one cycle");
	property p_flags_read;
		avs_read && wait_q && sel_flags |=> avs_readdata[2:0] == $past(lk.flags);
	endproperty
	a_flags_read: assert property (p_flags_read)
		else $error("flag register read back wrong value");
	property p_irq_set;
		|(lk.ev & mask_q) && !(wr && sel_mask) |=> irq;
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("unmasked event did not raise interrupt");
endmodule : rsc_regs
`default_nettype wire

// ---- tb/rsc_core_model.sv ----
// Behavioural model of the core, watchdog and power-down control
`timescale 1ns/10ps
`default_nettype none
module rsc_core_model (
	// Clock
	input wire logic core_clk,
	// Strobes from the controller
	input wire logic pc_sp_clr,
	input wire logic por_init,
	input wire logic core_hold,
	// Bench commands: bit0 power-on, bit1 overflow, bit2 halt, bit3 clear; mode; key; bit8 loads accumulator
	input wire logic [3:0] cmd_pulse,
	input wire logic cmd_lp,
	input wire logic [4:0] cmd_key,
	input wire logic [8:0] cmd_acc,
	// Requests to the controller
	output logic por_req,
	output logic wdt_timeout,
	output logic low_power,
	output logic [4:0] watchdog_key_field,
	output logic halt_enter,
	output logic clr_wdt,
	// Observed core state
	output logic [7:0] pc_q,
	output logic [7:0] acc_q
);
	// Requests leave one cycle after the command, as an issued instruction would
	always @(posedge core_clk) begin
		{clr_wdt, halt_enter, wdt_timeout, por_req} <= cmd_pulse;
		low_power <= cmd_lp;
		watchdog_key_field <= cmd_key;
	end
	// Program counter runs while the core is released
	always @(posedge core_clk) begin
		if (pc_sp_clr) begin
			pc_q <= 8'h00;
		end else if (!core_hold) begin
			pc_q <= pc_q + 8'h01;
		end
		// Accumulator is lost only on power-on, so it shows a wrongly issued init
		if (por_init) begin
			acc_q <= 8'h00;
		end else if (cmd_acc[8]) begin
			acc_q <= cmd_acc[7:0];
		end
	end
endmodule : rsc_core_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench of the reset source controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic core_clk, rst_n, por_req, wdt_timeout, low_power, halt_enter, clr_wdt;
	logic [4:0] watchdog_key_field;
	logic [3:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest, irq;
	logic [31:0] avs_writedata, avs_readdata, rdv;
	logic timeout_flag, power_down_flag, control_write_reset_flag;
	logic pc_sp_clr, por_init, wdt_tb_clr, core_hold;
	logic [3:0] ctrl_init;
	logic [2:0] reset_cause;
	logic [7:0] pc_q, acc_q;
	logic [3:0] cmd_pulse = 4'h0;
	logic cmd_lp = 1'b0;
	logic [4:0] cmd_key = rsc_pkg::KEY_ENABLE;
	logic [8:0] cmd_acc = 9'h000;
	int hold_exp = 0;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	initial core_clk = 1'b0;
	always #50 core_clk = ~core_clk;
	rsc_reset_ctrl i_rsc_reset_ctrl (.core_clk(core_clk), .rst_n(rst_n), .por_req(por_req),
		.wdt_timeout(wdt_timeout), .low_power(low_power), .watchdog_key_field(watchdog_key_field),
		.halt_enter(halt_enter), .clr_wdt(clr_wdt), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .timeout_flag(timeout_flag),
		.power_down_flag(power_down_flag), .control_write_reset_flag(control_write_reset_flag),
		.pc_sp_clr(pc_sp_clr), .por_init(por_init), .ctrl_init(ctrl_init), .wdt_tb_clr(wdt_tb_clr),
		.core_hold(core_hold), .reset_cause(reset_cause));
	rsc_core_model i_rsc_core_model (.core_clk(core_clk), .pc_sp_clr(pc_sp_clr), .por_init(por_init),
		.core_hold(core_hold), .por_req(por_req), .wdt_timeout(wdt_timeout), .low_power(low_power),
		.watchdog_key_field(watchdog_key_field), .halt_enter(halt_enter), .clr_wdt(clr_wdt),
		.cmd_pulse(cmd_pulse), .cmd_lp(cmd_lp), .cmd_key(cmd_key), .cmd_acc(cmd_acc), .pc_q(pc_q),
		.acc_q(acc_q));
	task summarize;
		$display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize
	// Bound on the whole run; the sequence needs well under a thousand cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			summarize();
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Request holds until waitrequest is sampled low at a rising edge
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		int n;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (avs_waitrequest !== 1'b0) begin
			num_errors++;
		end
		rdv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task rd(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rdv, exp);
	endtask : rd
	// One-cycle request pulse through the core model
	task pulse(input logic [3:0] m);
		@(posedge core_clk);
		cmd_pulse <= m;
		@(posedge core_clk);
		cmd_pulse <= 4'h0;
	endtask : pulse
	// Waits for the sequence strobe, checks it, then waits for the core release
	task expect_reset(input logic [2:0] c, input logic pi, input logic [3:0] ci, input logic t, input logic p);
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (pc_sp_clr !== 1'b1 && n < 80);
		check(pc_sp_clr, 1'b1);
		check(reset_cause, c);
		check(por_init, pi);
		check(ctrl_init, ci);
		check(wdt_tb_clr, 1'b1);
		check(core_hold, 1'b1);
		check(timeout_flag, t);
		check(power_down_flag, p);
		@(negedge core_clk);
		check(pc_q, 8'h00);
		n = 0;
		while (core_hold !== 1'b0 && n < 40) begin
			@(negedge core_clk);
			n++;
		end
		check(n, 1 + hold_exp);
	endtask : expect_reset
	initial begin
		rst_n = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		expect_reset(3'h1, 1'b1, 4'hf, 1'b0, 1'b0);
		@(posedge core_clk);
		cmd_acc <= 9'h15a;
		@(posedge core_clk);
		cmd_acc <= 9'h05a;
		rd(rsc_pkg::OFS_EVT, 32'h1);
		bus(1'b1, rsc_pkg::OFS_MASK, 32'hf);
		repeat (2) @(negedge core_clk);
		check(irq, 1'b1);
		bus(1'b1, rsc_pkg::OFS_EVT, 32'h1);
		repeat (2) @(negedge core_clk);
		check(irq, 1'b0);
		bus(1'b1, 4'h2, 32'hffffffff);
		rd(4'h2, 32'h0);
		rd(rsc_pkg::OFS_MASK, 32'hf);
		// Running-mode overflow keeps the power-down flag in both of its states
		pulse(4'h4);
		rd(rsc_pkg::OFS_FLAGS, 32'h2);
		pulse(4'h2);
		expect_reset(3'h2, 1'b0, 4'hf, 1'b1, 1'b1);
		check(acc_q, 8'h5a);
		pulse(4'h8);
		rd(rsc_pkg::OFS_FLAGS, 32'h0);
		pulse(4'h2);
		expect_reset(3'h2, 1'b0, 4'hf, 1'b1, 1'b0);
		// Overflow in sleep touches only counter, stack and flags
		@(posedge core_clk);
		cmd_lp <= 1'b1;
		pulse(4'h2);
		expect_reset(3'h3, 1'b0, 4'h0, 1'b1, 1'b1);
		@(posedge core_clk);
		cmd_lp <= 1'b0;
		check(acc_q, 8'h5a);
		rd(rsc_pkg::OFS_EVT, 32'h6);
		check(irq, 1'b1);
		bus(1'b1, rsc_pkg::OFS_EVT, 32'h6);
		// Bad key code resets after the delay and raises the write reset flag
		@(posedge core_clk);
		cmd_key <= 5'h1f;
		expect_reset(3'h4, 1'b0, 4'hf, 1'b1, 1'b1);
		check(control_write_reset_flag, 1'b1);
		@(posedge core_clk);
		cmd_key <= rsc_pkg::KEY_ENABLE;
		rd(rsc_pkg::OFS_FLAGS, 32'h7);
		bus(1'b1, rsc_pkg::OFS_FLAGS, 32'h7);
		rd(rsc_pkg::OFS_FLAGS, 32'h3);
		// Extra hold cycles stretch the next reset; power-on with overflow wins as power-on
		bus(1'b1, rsc_pkg::OFS_CTRL, 32'h3);
		rd(rsc_pkg::OFS_CTRL, 32'h3);
		hold_exp = 3;
		pulse(4'h3);
		expect_reset(3'h1, 1'b1, 4'hf, 1'b0, 1'b0);
		check(acc_q, 8'h00);
		summarize();
	end
endmodule : tb_top
`default_nettype wire
